//--- design/core_ctrl_pkg.sv
package core_ctrl_pkg;

   // Register byte offsets on the APB slave.
   localparam logic [7:0] CTRL_OFFSET       = 8'h00;
   localparam logic [7:0] STATUS_OFFSET     = 8'h04;
   localparam logic [7:0] INT_STATUS_OFFSET = 8'h08;
   localparam logic [7:0] INT_MASK_OFFSET   = 8'h0C;
   localparam logic [7:0] VECTOR_OFFSET     = 8'h10;

   // Control register fields.
   localparam int CTRL_INTR_EN_BIT = 0;
   localparam int CTRL_RESUME_BIT  = 1;
   localparam logic [1:0] CTRL_RESET_VALUE = 2'h0;

   // Status register fields.
   localparam int STATUS_STATE_LSB   = 0;
   localparam int STATUS_HALTED_BIT  = 4;
   localparam int STATUS_FAULT_BIT   = 5;
   localparam int STATUS_SLEEP_BIT   = 6;
   localparam int STATUS_DBG_WAKE_BIT = 7;
   localparam int STATUS_INTR_BUSY_BIT = 8;

   // Interrupt event bits, shared by status and mask registers.
   localparam int EVENT_COUNT    = 5;
   localparam int EV_HALTED_BIT  = 0;
   localparam int EV_SLEEP_BIT   = 1;
   localparam int EV_WAKE_BIT    = 2;
   localparam int EV_FAULT_BIT   = 3;
   localparam int EV_INTR_ACK_BIT = 4;
   localparam logic [EVENT_COUNT-1:0] INT_STATUS_RESET_VALUE = 5'h00;
   localparam logic [EVENT_COUNT-1:0] INT_MASK_RESET_VALUE   = 5'h00;

   // Parameter values that enable the optional features.
   localparam int DEBUG_ON_VALUE      = 1;
   localparam int FAULT_ON_VALUE      = 1;
   localparam int VECTORED_INTR_VALUE = 2;

   // Rising-edge detector channel positions.
   localparam int EDGE_CH_COUNT  = 2;
   localparam int EDGE_HALT_BIT  = 0;
   localparam int EDGE_RESUME_BIT = 1;

   typedef enum logic [2:0] {
      RUN_ST      = 3'b000,
      DRAIN_ST    = 3'b001,
      SLEEP_ST    = 3'b010,
      DBG_HALT_ST = 3'b011,
      FAULT_ST    = 3'b100
   } core_state_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;

endpackage

//--- design/core_halt_sleep_control.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Either reset input gives identical core reset.
// - Halt request edge halts pipeline if debug on.
// - Halted output high while debug halt holds an idle pipeline.
// - Fault flag on missed exception, fault option.
// - Sleep only after accesses done, pipeline idle.
// - Any wake bit ends sleep.
// - Wake bits ignored outside sleep.
// - Debug wake request drives external wake logic.
// - Vector and acknowledge only in mode two.
// - Core logic runs on the core clock.
module core_halt_sleep_control
   import core_ctrl_pkg::*;
#(
   parameter int DEBUG_ENABLED         = 1,
   parameter int FAULT_TOLERANCE_PARAM = 1,
   parameter int INTERRUPT_MODE        = 2,
   parameter int VECTOR_WIDTH          = 32
) (
   input  wire logic                    CLK_SYS_I,
   input  wire logic                    RESET_N_I,
   input  wire logic                    CORE_RESET_I,
   input  wire logic                    CORE_RESET_ALT_I,
   input  wire logic                    DBG_HALT_REQ_I,
   input  wire logic                    DBG_IF_HALT_I,
   input  wire logic                    DBG_RESUME_I,
   input  wire logic                    DBG_WAKE_REQ_I,
   input  wire logic                    SLEEP_INSTR_I,
   input  wire logic                    EXT_BUSY_I,
   input  wire logic                    PIPE_IDLE_I,
   input  wire logic                    MISSED_EXC_I,
   input  wire logic [1:0]              WAKEUP_I,
   input  wire logic                    INTR_I,
   input  wire logic [VECTOR_WIDTH-1:0] INTR_ADDR_I,
   input  wire apb_req_type             APB_REQ_I,
   output apb_rsp_type                  APB_RSP_O,
   output logic                         CORE_RESET_O,
   output logic                         STALL_O,
   output logic                         PIPELINE_HALTED_FLAG_O,
   output logic                         FAULT_HALT_FLAG_O,
   output logic                         SLEEP_O,
   output logic                         DBG_WAKEUP_O,
   output logic                         INTR_ACK_O,
   output logic [VECTOR_WIDTH-1:0]      INTR_VECTOR_O,
   output logic                         IRQ_O
);

   typedef struct packed {
      core_state_type          state;
      logic                    core_reset;
      logic                    halted;
      logic                    fault;
      logic                    sleep;
      logic                    dbg_wake;
      logic                    intr_ack;
      logic                    intr_busy;
      logic [VECTOR_WIDTH-1:0] vector;
      logic [1:0]              ctrl;
      logic [EVENT_COUNT-1:0]  int_status;
      logic [EVENT_COUNT-1:0]  int_mask;
      logic [31:0]             prdata;
   } ctrl_state_type;

   ctrl_state_type s_q;
   ctrl_state_type s_d;

   logic                     reset_any;
   logic [EDGE_CH_COUNT-1:0] dbg_level;
   logic [EDGE_CH_COUNT-1:0] dbg_rise;
   logic                     halt_req;
   logic                     resume_req;
   logic                     fault_req;
   logic                     wake_req;
   logic                     apb_setup;
   logic                     apb_access;
   logic                     apb_write;
   logic [EVENT_COUNT-1:0]   events;
   logic [31:0]              read_data;

   // Decodes an APB address to whether a register lives there.
   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET) ||
             (addr == INT_STATUS_OFFSET) || (addr == INT_MASK_OFFSET) ||
             (addr == VECTOR_OFFSET);
   endfunction

   // Either reset input resets the core the same way.
   assign reset_any = CORE_RESET_I | CORE_RESET_ALT_I;

   assign dbg_level[EDGE_HALT_BIT]   = DBG_HALT_REQ_I;
   assign dbg_level[EDGE_RESUME_BIT] = DBG_RESUME_I;

   // The halt request is edge detected; a level held for one clock is seen.
   rise_detect #(
      .WIDTH (EDGE_CH_COUNT)
   ) u_rise_detect (
      .clk_i     (CLK_SYS_I),
      .reset_n_i (RESET_N_I),
      .clear_i   (reset_any),
      .level_i   (dbg_level),
      .rise_o    (dbg_rise)
   );

   assign halt_req = (DEBUG_ENABLED == DEBUG_ON_VALUE) &&
                     (dbg_rise[EDGE_HALT_BIT] || DBG_IF_HALT_I);

   assign resume_req = (dbg_rise[EDGE_RESUME_BIT] ||
                        (apb_write && (APB_REQ_I.paddr == CTRL_OFFSET) &&
                         APB_REQ_I.pwdata[CTRL_RESUME_BIT])) && !DBG_IF_HALT_I;

   assign fault_req = (FAULT_TOLERANCE_PARAM == FAULT_ON_VALUE) && MISSED_EXC_I;

   // Wake bits only count while sleeping.
   assign wake_req = (s_q.state == SLEEP_ST) && (|WAKEUP_I);

   assign apb_setup  = APB_REQ_I.psel && !APB_REQ_I.penable;
   assign apb_access = APB_REQ_I.psel && APB_REQ_I.penable;
   assign apb_write  = apb_access && APB_REQ_I.pwrite;

   // Builds the read word during the setup phase.
   always_comb begin
      read_data = 32'h0000_0000;
      case (APB_REQ_I.paddr)
         CTRL_OFFSET: begin
            read_data[CTRL_INTR_EN_BIT] = s_q.ctrl[CTRL_INTR_EN_BIT];
         end
         STATUS_OFFSET: begin
            read_data[STATUS_STATE_LSB +: 3]  = s_q.state;
            read_data[STATUS_HALTED_BIT]      = s_q.halted;
            read_data[STATUS_FAULT_BIT]       = s_q.fault;
            read_data[STATUS_SLEEP_BIT]       = s_q.sleep;
            read_data[STATUS_DBG_WAKE_BIT]    = s_q.dbg_wake;
            read_data[STATUS_INTR_BUSY_BIT]   = s_q.intr_busy;
         end
         INT_STATUS_OFFSET: begin
            read_data[EVENT_COUNT-1:0] = s_q.int_status;
         end
         INT_MASK_OFFSET: begin
            read_data[EVENT_COUNT-1:0] = s_q.int_mask;
         end
         VECTOR_OFFSET: begin
            read_data[VECTOR_WIDTH-1:0] = s_q.vector;
         end
         default: begin
            read_data = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      s_d    = s_q;
      events = '0;

      s_d.core_reset = reset_any;
      s_d.intr_ack   = 1'b0;
      s_d.ctrl[CTRL_RESUME_BIT] = 1'b0;

      if (reset_any) begin
         s_d.state     = RUN_ST;
         s_d.halted    = 1'b0;
         s_d.fault     = 1'b0;
         s_d.sleep     = 1'b0;
         s_d.dbg_wake  = 1'b0;
         s_d.intr_busy = 1'b0;
         s_d.vector    = '0;
      end else begin
         case (s_q.state)
            RUN_ST: begin
               if (fault_req) begin
                  s_d.state = FAULT_ST;
               end else if (halt_req) begin
                  s_d.state = DBG_HALT_ST;
               end else if (SLEEP_INSTR_I) begin
                  s_d.state = DRAIN_ST;
               end
            end
            DRAIN_ST: begin
               if (fault_req) begin
                  s_d.state = FAULT_ST;
               end else if (halt_req) begin
                  s_d.state = DBG_HALT_ST;
               end else if (!EXT_BUSY_I && PIPE_IDLE_I) begin
                  s_d.state = SLEEP_ST;
                  events[EV_SLEEP_BIT] = 1'b1;
               end
            end
            SLEEP_ST: begin
               if (fault_req) begin
                  s_d.state = FAULT_ST;
               end else if (halt_req) begin
                  s_d.state = DBG_HALT_ST;
               end else if (wake_req) begin
                  s_d.state = RUN_ST;
                  events[EV_WAKE_BIT] = 1'b1;
               end
            end
            DBG_HALT_ST: begin
               if (fault_req) begin
                  s_d.state = FAULT_ST;
               end else if (resume_req) begin
                  s_d.state = RUN_ST;
               end
            end
            FAULT_ST: begin
               s_d.state = FAULT_ST;
            end
            default: begin
               s_d.state = RUN_ST;
            end
         endcase

         // Halted once the pipeline has drained under a debug stop.
         s_d.halted = (s_d.state == DBG_HALT_ST) && PIPE_IDLE_I;
         if (s_d.halted && !s_q.halted) begin
            events[EV_HALTED_BIT] = 1'b1;
         end

         s_d.fault = (s_d.state == FAULT_ST) && PIPE_IDLE_I;
         if (s_d.fault && !s_q.fault) begin
            events[EV_FAULT_BIT] = 1'b1;
         end

         s_d.sleep = (s_d.state == SLEEP_ST);

         // Held until the core leaves sleep, through the wake bits, a halt or a fault.
         if (s_d.state == SLEEP_ST || s_d.state == DRAIN_ST) begin
            s_d.dbg_wake = s_q.dbg_wake ||
                           ((DEBUG_ENABLED == DEBUG_ON_VALUE) && DBG_WAKE_REQ_I);
         end else begin
            s_d.dbg_wake = 1'b0;
         end

         // Vectored interrupt: one acknowledge per request level.
         if (INTERRUPT_MODE == VECTORED_INTR_VALUE) begin
            if (!INTR_I) begin
               s_d.intr_busy = 1'b0;
            end else if (!s_q.intr_busy && s_q.state == RUN_ST && s_d.state == RUN_ST &&
                         s_q.ctrl[CTRL_INTR_EN_BIT]) begin
               s_d.intr_busy = 1'b1;
               s_d.intr_ack  = 1'b1;
               s_d.vector    = INTR_ADDR_I;
               events[EV_INTR_ACK_BIT] = 1'b1;
            end
         end else begin
            s_d.intr_busy = 1'b0;
            s_d.vector    = '0;
         end
      end

      // Register writes take effect in the access phase.
      if (apb_write) begin
         case (APB_REQ_I.paddr)
            CTRL_OFFSET: begin
               s_d.ctrl[CTRL_INTR_EN_BIT] = APB_REQ_I.pwdata[CTRL_INTR_EN_BIT];
               s_d.ctrl[CTRL_RESUME_BIT]  = APB_REQ_I.pwdata[CTRL_RESUME_BIT];
            end
            INT_STATUS_OFFSET: begin
               s_d.int_status = s_q.int_status & ~APB_REQ_I.pwdata[EVENT_COUNT-1:0];
            end
            INT_MASK_OFFSET: begin
               s_d.int_mask = APB_REQ_I.pwdata[EVENT_COUNT-1:0];
            end
            default: begin
               s_d.int_mask = s_q.int_mask;
            end
         endcase
      end

      // A new event wins over a clear in the same cycle.
      s_d.int_status = s_d.int_status | events;

      if (apb_setup) begin
         s_d.prdata = read_data;
      end
   end

   // Every flop sits on the single core clock.
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         s_q.state      <= RUN_ST;
         s_q.core_reset <= 1'b0;
         s_q.halted     <= 1'b0;
         s_q.fault      <= 1'b0;
         s_q.sleep      <= 1'b0;
         s_q.dbg_wake   <= 1'b0;
         s_q.intr_ack   <= 1'b0;
         s_q.intr_busy  <= 1'b0;
         s_q.vector     <= '0;
         s_q.ctrl       <= CTRL_RESET_VALUE;
         s_q.int_status <= INT_STATUS_RESET_VALUE;
         s_q.int_mask   <= INT_MASK_RESET_VALUE;
         s_q.prdata     <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign APB_RSP_O.prdata  = s_q.prdata;
   assign APB_RSP_O.pready  = 1'b1;
   assign APB_RSP_O.pslverr = apb_access && !is_mapped(APB_REQ_I.paddr);

   assign CORE_RESET_O           = s_q.core_reset;
   assign STALL_O                = (s_q.state != RUN_ST);
   assign PIPELINE_HALTED_FLAG_O = s_q.halted;
   assign FAULT_HALT_FLAG_O      = s_q.fault;
   assign SLEEP_O                = s_q.sleep;
   assign DBG_WAKEUP_O           = s_q.dbg_wake;
   assign INTR_ACK_O             = s_q.intr_ack;
   assign INTR_VECTOR_O          = s_q.vector;
   assign IRQ_O                  = |(s_q.int_status & s_q.int_mask);

endmodule // core_halt_sleep_control

//--- design/rise_detect.sv
`timescale 1ns/1ps
module rise_detect
   import core_ctrl_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             clear_i,
   input  wire logic [WIDTH-1:0] level_i,
   output logic      [WIDTH-1:0] rise_o
);

   typedef struct packed {
      logic [WIDTH-1:0] prev_q;
   } edge_state_type;

   edge_state_type s_q;
   edge_state_type s_d;

   // Compares each sample with the one from the previous clock.
   always_comb begin
      s_d        = s_q;
      s_d.prev_q = clear_i ? '0 : level_i;
   end

   assign rise_o = level_i & ~s_q.prev_q;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // rise_detect

//--- verification/core_ctrl_props.sv
`timescale 1ns/1ps
module core_ctrl_props
   import core_ctrl_pkg::*;
#(
   parameter int VECTOR_WIDTH = 32
) (
   input wire logic                    CLK_SYS_I,
   input wire logic                    RESET_N_I,
   input wire logic                    CORE_RESET_I,
   input wire logic                    CORE_RESET_ALT_I,
   input wire logic                    DBG_HALT_REQ_I,
   input wire logic                    DBG_RESUME_I,
   input wire logic                    EXT_BUSY_I,
   input wire logic                    PIPE_IDLE_I,
   input wire logic                    MISSED_EXC_I,
   input wire logic [1:0]              WAKEUP_I,
   input wire logic [VECTOR_WIDTH-1:0] INTR_ADDR_I,
   input wire apb_req_type             APB_REQ_I,
   input wire logic                    CORE_RESET_O,
   input wire logic                    STALL_O,
   input wire logic                    PIPELINE_HALTED_FLAG_O,
   input wire logic                    FAULT_HALT_FLAG_O,
   input wire logic                    SLEEP_O,
   input wire logic                    DBG_WAKEUP_O,
   input wire logic                    INTR_ACK_O,
   input wire logic [VECTOR_WIDTH-1:0] INTR_VECTOR_O
);
   logic rst_any;
   logic reg_wr;
   assign rst_any = CORE_RESET_I | CORE_RESET_ALT_I;
   assign reg_wr  = APB_REQ_I.psel & APB_REQ_I.pwrite;
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESET_N_I);
   sequence woken_s;
      !SLEEP_O ##1 !SLEEP_O;
   endsequence
   sequence ack_s;
      (INTR_VECTOR_O == $past(INTR_ADDR_I)) ##1 !INTR_ACK_O;
   endsequence
   chk_core_reset: assert property (rst_any |=> CORE_RESET_O && !STALL_O)
      else $error("core reset not applied");
   chk_halt_edge: assert property ($rose(DBG_HALT_REQ_I) && !rst_any |=> STALL_O)
      else $error("halt edge did not stall");
   chk_halted_flag: assert property ($rose(DBG_HALT_REQ_I) && PIPE_IDLE_I && !STALL_O
      && !MISSED_EXC_I && !rst_any |=> PIPELINE_HALTED_FLAG_O)
      else $error("halted flag missing");
   chk_fault_flag: assert property (MISSED_EXC_I && PIPE_IDLE_I && !rst_any
      |=> FAULT_HALT_FLAG_O && STALL_O)
      else $error("fault flag missing");
   chk_sleep_entry: assert property ($rose(SLEEP_O) |-> !$past(EXT_BUSY_I) && $past(PIPE_IDLE_I))
      else $error("sleep before drain");
   chk_wake_exit: assert property (SLEEP_O && (WAKEUP_I != 2'h0) |=> woken_s)
      else $error("wake bits did not wake");
   chk_wake_ignored: assert property (STALL_O && !SLEEP_O && !DBG_RESUME_I && !reg_wr
      && !rst_any |=> STALL_O)
      else $error("stall left without cause");
   chk_dbg_wake: assert property (DBG_WAKEUP_O |-> STALL_O)
      else $error("debug wake while running");
   chk_ack_pulse: assert property (INTR_ACK_O |-> ack_s)
      else $error("acknowledge or vector wrong");
endmodule // core_ctrl_props

//--- verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITC(c) begin for (w = 0; w < 40 && !(c); w++) @(negedge CLK_SYS_I); \
   if (!(c)) begin bad_count++; finish_test(); end end
module tb;
   import core_ctrl_pkg::*;
   logic        CLK_SYS_I, RESET_N_I, CORE_RESET_I, CORE_RESET_ALT_I, DBG_HALT_REQ_I;
   logic        DBG_IF_HALT_I, DBG_RESUME_I, DBG_WAKE_REQ_I, SLEEP_INSTR_I, EXT_BUSY_I;
   logic        PIPE_IDLE_I, MISSED_EXC_I, INTR_I, CORE_RESET_O, STALL_O, SLEEP_O, err;
   logic        PIPELINE_HALTED_FLAG_O, FAULT_HALT_FLAG_O, DBG_WAKEUP_O, INTR_ACK_O, IRQ_O;
   logic [1:0]  WAKEUP_I, ext_wake;
   logic [3:0]  delay;
   logic [31:0] INTR_ADDR_I, INTR_VECTOR_O, seed, rd, exp_ev;
   logic [31:0] vec_q[$];
   apb_req_type APB_REQ_I;
   apb_rsp_type APB_RSP_O;
   int          bad_count = 0;
   int          check_count = 0;
   int          w;
   core_halt_sleep_control dut_u (.*);
   wake_partner wp_u (.clk_i(CLK_SYS_I), .reset_n_i(RESET_N_I), .dbg_wakeup_i(DBG_WAKEUP_O),
      .sleep_i(SLEEP_O), .delay_i(delay), .ext_wake_i(ext_wake), .wakeup_o(WAKEUP_I));
   initial begin
      CLK_SYS_I = 1'b0;
      forever #50 CLK_SYS_I = ~CLK_SYS_I;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS_I);
      APB_REQ_I <= '{1'b1, 1'b0, wr, a, d};
      @(posedge CLK_SYS_I);
      APB_REQ_I.penable <= 1'b1;
      for (w = 0; w < 20; w++) begin
         @(posedge CLK_SYS_I);
         if (APB_RSP_O.pready === 1'b1) break;
      end
      if (w == 20) begin
         bad_count++;
         finish_test();
      end
      rd = APB_RSP_O.prdata;
      err = APB_RSP_O.pslverr;
      APB_REQ_I <= '0;
   endtask
   task go_sleep(input logic [1:0] hold);
      @(posedge CLK_SYS_I);
      SLEEP_INSTR_I <= 1'b1;
      EXT_BUSY_I <= hold[0];
      PIPE_IDLE_I <= !hold[1];
      ext_wake <= 2'h3;
      @(posedge CLK_SYS_I);
      SLEEP_INSTR_I <= 1'b0;
      ext_wake <= {2{|hold}};
      repeat (3) @(negedge CLK_SYS_I);
      `CHK({SLEEP_O, STALL_O}, {~|hold, 1'b1})
      @(posedge CLK_SYS_I);
      EXT_BUSY_I <= 1'b0;
      PIPE_IDLE_I <= 1'b1;
      ext_wake <= 2'h0;
      `WAITC(SLEEP_O === 1'b1)
   endtask
   initial begin
      {CORE_RESET_I, CORE_RESET_ALT_I, DBG_HALT_REQ_I, DBG_IF_HALT_I, DBG_RESUME_I,
         DBG_WAKE_REQ_I, SLEEP_INSTR_I, EXT_BUSY_I, MISSED_EXC_I, INTR_I, RESET_N_I} = '0;
      {INTR_ADDR_I, ext_wake, delay, exp_ev} = '0;
      APB_REQ_I = '0;
      PIPE_IDLE_I = 1'b1;
      seed = 32'h6;
      repeat (3) @(posedge CLK_SYS_I);
      RESET_N_I <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK({err, rd}, {1'(i == 5), 32'h0})
      end
      apb(1'b1, INT_MASK_OFFSET, 32'h1F);
      apb(1'b1, CTRL_OFFSET, 32'h1);
      @(posedge CLK_SYS_I);
      DBG_HALT_REQ_I <= 1'b1;
      ext_wake <= 2'h3;
      repeat (2) @(negedge CLK_SYS_I);
      `CHK({STALL_O, PIPELINE_HALTED_FLAG_O}, 2'h3)
      @(posedge CLK_SYS_I);
      DBG_RESUME_I <= 1'b1;
      ext_wake <= 2'h0;
      @(posedge CLK_SYS_I);
      DBG_RESUME_I <= 1'b0;
      repeat (3) @(negedge CLK_SYS_I);
      `CHK(STALL_O, 1'b0)
      @(posedge CLK_SYS_I);
      DBG_HALT_REQ_I <= 1'b0;
      DBG_IF_HALT_I <= 1'b1;
      DBG_RESUME_I <= 1'b1;
      repeat (3) @(negedge CLK_SYS_I);
      `CHK(PIPELINE_HALTED_FLAG_O, 1'b1)
      @(posedge CLK_SYS_I);
      DBG_IF_HALT_I <= 1'b0;
      DBG_RESUME_I <= 1'b0;
      apb(1'b1, CTRL_OFFSET, 32'h3);
      repeat (2) @(negedge CLK_SYS_I);
      `CHK({STALL_O, PIPELINE_HALTED_FLAG_O}, 2'h0)
      for (int v = 1; v < 4; v++) begin
         go_sleep(2'(v - 1));
         @(posedge CLK_SYS_I);
         ext_wake <= 2'(v);
         repeat (2) @(negedge CLK_SYS_I);
         `CHK({SLEEP_O, STALL_O}, 2'h0)
         @(posedge CLK_SYS_I);
         ext_wake <= 2'h0;
      end
      for (int v = 0; v < 2; v++) begin
         go_sleep(2'h0);
         @(posedge CLK_SYS_I);
         delay <= 4'(5 * v);
         DBG_WAKE_REQ_I <= 1'b1;
         `WAITC(DBG_WAKEUP_O === 1'b1)
         `CHK(SLEEP_O, 1'b1)
         `WAITC(SLEEP_O === 1'b0)
         @(negedge CLK_SYS_I);
         `CHK(DBG_WAKEUP_O, 1'b0)
         @(posedge CLK_SYS_I);
         DBG_WAKE_REQ_I <= 1'b0;
      end
      exp_ev = 32'h7;
      apb(1'b0, INT_STATUS_OFFSET, 32'h0);
      `CHK(rd, exp_ev)
      apb(1'b1, INT_STATUS_OFFSET, 32'h1F);
      repeat (2) begin
         seed = lfsr(seed);
         vec_q.push_back(seed);
         @(posedge CLK_SYS_I);
         INTR_ADDR_I <= seed;
         INTR_I <= 1'b1;
         repeat (2) @(negedge CLK_SYS_I);
         `CHK({INTR_ACK_O, INTR_VECTOR_O}, {1'b1, seed})
         @(negedge CLK_SYS_I);
         `CHK({INTR_ACK_O, IRQ_O}, 2'h1)
         @(posedge CLK_SYS_I);
         INTR_I <= 1'b0;
         INTR_ADDR_I <= lfsr(seed);
         apb(1'b0, VECTOR_OFFSET, 32'h0);
         `CHK(rd, vec_q.pop_front())
      end
      apb(1'b1, INT_MASK_OFFSET, 32'h0F);
      repeat (2) @(negedge CLK_SYS_I);
      `CHK(IRQ_O, 1'b0)
      apb(1'b1, CTRL_OFFSET, 32'h0);
      @(posedge CLK_SYS_I);
      INTR_I <= 1'b1;
      repeat (2) @(negedge CLK_SYS_I);
      `CHK({INTR_ACK_O, INTR_VECTOR_O}, {1'b0, seed})
      @(posedge CLK_SYS_I);
      INTR_I <= 1'b0;
      for (int j = 0; j < 2; j++) begin
         @(posedge CLK_SYS_I);
         MISSED_EXC_I <= 1'b1;
         @(posedge CLK_SYS_I);
         MISSED_EXC_I <= 1'b0;
         DBG_RESUME_I <= 1'b1;
         ext_wake <= 2'h3;
         repeat (3) @(negedge CLK_SYS_I);
         `CHK({FAULT_HALT_FLAG_O, STALL_O}, 2'h3)
         @(posedge CLK_SYS_I);
         {CORE_RESET_ALT_I, CORE_RESET_I} <= 2'(j + 1);
         DBG_RESUME_I <= 1'b0;
         ext_wake <= 2'h0;
         @(posedge CLK_SYS_I);
         {CORE_RESET_ALT_I, CORE_RESET_I} <= 2'h0;
         @(negedge CLK_SYS_I);
         `CHK({CORE_RESET_O, FAULT_HALT_FLAG_O, STALL_O}, 3'h4)
      end
      exp_ev = 32'h18;
      apb(1'b0, INT_STATUS_OFFSET, 32'h0);
      `CHK(rd, exp_ev)
      finish_test();
   end
endmodule // tb
bind core_halt_sleep_control core_ctrl_props #(.VECTOR_WIDTH(VECTOR_WIDTH)) chk_u (.*);

//--- verification/wake_partner.sv
`timescale 1ns/1ps
module wake_partner (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       dbg_wakeup_i,
   input  wire logic       sleep_i,
   input  wire logic [3:0] delay_i,
   input  wire logic [1:0] ext_wake_i,
   output logic      [1:0] wakeup_o
);
   logic [3:0] wait_q;
   logic [1:0] resp_q;
   // Answers a debug wake request after a chosen delay and lets go once awake.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_q <= 4'h0;
         resp_q <= 2'h0;
      end else if (dbg_wakeup_i && sleep_i) begin
         wait_q <= wait_q + 4'h1;
         if (wait_q == delay_i) begin
            resp_q <= 2'h2;
         end
      end else begin
         wait_q <= 4'h0;
         resp_q <= 2'h0;
      end
   end
   assign wakeup_o = resp_q | ext_wake_i;
endmodule // wake_partner
